/* File: src/iwrc_pkg.sv */
// Purpose: Shared constants and types for the idle, wake and reset-cause block
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word each
// Notes:   Byte addresses below are word aligned; data uses bits 7:0
package iwrc_pkg;
  // Register byte addresses
  localparam logic [3:0] ADR_RCAUSE = 4'h0;
  localparam logic [3:0] ADR_PCTRL = 4'h4;
  localparam logic [3:0] ADR_PSTAT = 4'h8;
  // reset_cause_register field positions
  localparam int RC_IRQ_LEVEL_ENABLE = 7;
  localparam int RC_CM = 5;
  localparam int RC_RI = 4;
  localparam int RC_TO = 3;
  localparam int RC_PD = 2;
  localparam int RC_POR = 1;
  localparam int RC_BOR = 0;
  localparam logic [7:0] RC_RESET = 8'h3C;
  localparam logic [7:0] RC_WMASK = 8'hB3;
  // power_control_register field positions
  localparam int PC_IDLE_ON_SLEEP_SELECT = 0;
  localparam int PC_SCS = 1;
  localparam int PC_T1EN = 3;
  localparam int PC_WDTEN = 4;
  localparam int PC_FSCM = 5;
  localparam logic [7:0] PC_RESET = 8'h04;
  localparam logic [7:0] PC_WMASK = 8'h3F;
  // Clock select and main oscillator configuration codes
  localparam logic [1:0] SCS_SEC = 2'h1;
  localparam logic [1:0] SCS_MAIN = 2'h2;
  localparam logic [1:0] MAIN_OSC_CONFIG_EC = 2'h1;
  localparam logic [1:0] MAIN_OSC_CONFIG_EXTERNAL_CLOCK_PLL_MODE = 2'h3;
  // Timing in core_clk cycles
  localparam int DLY_W = 12;
  localparam logic [DLY_W-1:0] WAKE_DLY_CYC = 12'h008;
  localparam logic [DLY_W-1:0] OST_CYC = 12'h400;
  typedef enum logic [1:0] {
    M_RUN = 2'b00,
    M_IDLE = 2'b01,
    M_SLEEP = 2'b10,
    M_WAKE = 2'b11
  } iwrc_mode_e;
  typedef enum logic [1:0] {
    SRC_INT = 2'b00,
    SRC_SEC = 2'b01,
    SRC_MAIN = 2'b10,
    SRC_NONE = 2'b11
  } iwrc_src_e;
endpackage

/* File: src/iwrc_reg_if.sv */
// Purpose: Register access carrier between bus slave and control core
// Assumes: wr is a one-cycle strobe in the cycle that ack is high
// Notes:   rdata is decoded combinationally from addr by the core
`timescale 1ns/100ps
interface iwrc_reg_if;
  logic wr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface

/* File: src/iwrc_delay.sv */
// Purpose: Down counter that times the wake interval
// Assumes: load value is at least one
// Notes:   done is high in the last cycle of the interval
`timescale 1ns/100ps
module iwrc_delay #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] val,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = load ? val : (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !load;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // iwrc_delay

/* File: src/iwrc_wb.sv */
// Purpose: Classic Wishbone slave in front of the register core
// Assumes: Master holds the request until it samples ack
// Notes:   Ack one cycle after the request; unmapped reads return zero
`timescale 1ns/100ps
module iwrc_wb (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  iwrc_reg_if.bus rif
);
  logic ack_r;
  logic [7:0] dat_r;
  wire req = wb_cyc_i && wb_stb_i && !ack_r;

  // Write lands on the edge where the master sees ack
  assign rif.wr = ack_r && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign rif.addr = wb_adr_i;
  assign rif.wdata = wb_dat_i[7:0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h000000, dat_r};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      dat_r <= 8'h00;
    end else begin
      ack_r <= req;
      if (req) begin
        dat_r <= rif.rdata;
      end
    end
  end
endmodule // iwrc_wb

/* File: src/iwrc_top.sv */
// Purpose: Idle and sleep entry, wake sequencing and reset-cause register
// Assumes: Event inputs are one-cycle pulses synchronous to core_clk
// Notes:   arst_n is the power-on reset; other resets arrive as pulses
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module iwrc_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic [7:0] irq_flags,
  input wire logic [7:0] irq_enables,
  input wire logic global_irq_enable,
  input wire logic wdt_timeout,
  input wire logic clock_lost,
  input wire logic bor_event,
  input wire logic cm_event,
  input wire logic reset_instr_event,
  input wire logic vreg_enable,
  input wire logic [1:0] main_osc_config,
  output logic cpu_clk_en,
  output logic [1:0] periph_src,
  output logic main_osc_on,
  output logic sec_osc_on,
  output logic int_osc_on,
  output logic main_clock_active_flag,
  output logic secondary_clock_active_flag,
  output logic wdt_clear,
  output logic wdt_reset_req,
  output logic cpu_resume,
  output logic irq_vector_branch,
  output logic irq_level_enable
);
  ////////////////////////////////////////////////////////////////////////
  iwrc_reg_if rif ();

  iwrc_wb u_wb (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif)
  );

  iwrc_pkg::iwrc_mode_e mode_r, mode_nxt;
  iwrc_pkg::iwrc_src_e src_r, src_nxt, scs_src;
  logic [7:0] rc_r, rc_nxt;
  logic [7:0] pc_r, pc_nxt;
  logic irq_wake_r, irq_wake_nxt;
  logic gie_r, gie_nxt;
  logic cpu_r, main_on_r, sec_on_r, int_on_r, mflag_r, sflag_r;
  logic wclr_r, wrst_r, resume_r, vec_r;
  logic dly_load, dly_done;
  logic [iwrc_pkg::DLY_W-1:0] dly_val;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire [1:0] system_clock_select = pc_r[iwrc_pkg::PC_SCS +: 2];
  wire idle_on_sleep_select = pc_r[iwrc_pkg::PC_IDLE_ON_SLEEP_SELECT];
  wire t1en = pc_r[iwrc_pkg::PC_T1EN];
  wire wdt_en = pc_r[iwrc_pkg::PC_WDTEN];
  wire fscm_en = pc_r[iwrc_pkg::PC_FSCM];
  wire in_run = (mode_r == iwrc_pkg::M_RUN);
  wire asleep = (mode_r == iwrc_pkg::M_IDLE) ||
                (mode_r == iwrc_pkg::M_SLEEP);
  wire wake_irq = |(irq_flags & irq_enables);
  wire wake_any = wake_irq || wdt_timeout;
  wire wdt_rst = in_run && wdt_timeout;
  wire rst_evt = bor_event || cm_event || reset_instr_event || wdt_rst;
  wire sec_bad = idle_on_sleep_select && (system_clock_select == iwrc_pkg::SCS_SEC) && !t1en;
  wire sleep_ok = in_run && sleep_instr && !sec_bad;
  wire ext_main = (main_osc_config == iwrc_pkg::MAIN_OSC_CONFIG_EC) ||
                  (main_osc_config == iwrc_pkg::MAIN_OSC_CONFIG_EXTERNAL_CLOCK_PLL_MODE);
  // Start-up wait only when a stopped crystal must restart
  wire need_ost = (mode_r == iwrc_pkg::M_SLEEP) &&
                  (scs_src == iwrc_pkg::SRC_MAIN) && !ext_main;
  wire sel_rc = rif.addr == iwrc_pkg::ADR_RCAUSE;
  wire sel_pc = rif.addr == iwrc_pkg::ADR_PCTRL;
  wire sel_ps = rif.addr == iwrc_pkg::ADR_PSTAT;
  wire [7:0] pstat = {1'b0, sflag_r, mflag_r, cpu_r, src_r, mode_r};

  // Clear select falls to the RC; 10 picks main, 01 secondary
  assign scs_src = (system_clock_select == iwrc_pkg::SCS_MAIN) ? iwrc_pkg::SRC_MAIN :
                   (system_clock_select == iwrc_pkg::SCS_SEC) ? iwrc_pkg::SRC_SEC :
                   iwrc_pkg::SRC_INT;
  assign rif.rdata = sel_rc ? rc_r : sel_pc ? pc_r : sel_ps ? pstat : 8'h00;
  assign dly_load = asleep && wake_any && !rst_evt;
  assign dly_val = need_ost ?
                   iwrc_pkg::DLY_W'(iwrc_pkg::WAKE_DLY_CYC + iwrc_pkg::OST_CYC) :
                   iwrc_pkg::WAKE_DLY_CYC;

  iwrc_delay #(
    .W(iwrc_pkg::DLY_W)
  ) u_dly (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(dly_load),
    .val(dly_val),
    .done(dly_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    src_nxt = src_r;
    irq_wake_nxt = irq_wake_r;
    gie_nxt = gie_r;
    case (mode_r)
      iwrc_pkg::M_RUN: begin
        if (sleep_ok && idle_on_sleep_select) begin
          mode_nxt = iwrc_pkg::M_IDLE;
          src_nxt = scs_src;
        end else if (sleep_ok) begin
          mode_nxt = iwrc_pkg::M_SLEEP;
          src_nxt = iwrc_pkg::SRC_NONE;
        end
      end
      iwrc_pkg::M_IDLE, iwrc_pkg::M_SLEEP: begin
        if (wake_any) begin
          mode_nxt = iwrc_pkg::M_WAKE;
          irq_wake_nxt = wake_irq;
          gie_nxt = global_irq_enable;
          // Idle keeps its source; sleep wakes to the selected one
          if (mode_r == iwrc_pkg::M_SLEEP) begin
            src_nxt = scs_src;
          end
        end
      end
      iwrc_pkg::M_WAKE: begin
        if (dly_done) begin
          mode_nxt = iwrc_pkg::M_RUN;
        end
      end
      default: begin
        mode_nxt = iwrc_pkg::M_RUN;
      end
    endcase
    if (rst_evt) begin
      mode_nxt = iwrc_pkg::M_RUN;
      irq_wake_nxt = 1'b0;
      if (!in_run) begin
        src_nxt = iwrc_pkg::SRC_INT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; hardware events are applied last so they beat a write
  always_comb begin
    rc_nxt = rc_r;
    pc_nxt = pc_r;
    if (rif.wr && sel_rc) begin
      rc_nxt = (rc_r & ~iwrc_pkg::RC_WMASK) |
               (rif.wdata & iwrc_pkg::RC_WMASK);
    end
    if (rif.wr && sel_pc) begin
      pc_nxt = rif.wdata & iwrc_pkg::PC_WMASK;
    end
    if (sleep_ok) begin
      rc_nxt[iwrc_pkg::RC_TO] = 1'b1;
      rc_nxt[iwrc_pkg::RC_PD] = 1'b0;
    end
    if (watchdog_clear_instr) begin
      rc_nxt[iwrc_pkg::RC_TO] = 1'b1;
      rc_nxt[iwrc_pkg::RC_PD] = 1'b1;
    end
    if (wdt_timeout) begin
      rc_nxt[iwrc_pkg::RC_TO] = 1'b0;
    end
    if (cm_event) begin
      rc_nxt[iwrc_pkg::RC_CM] = 1'b0;
    end
    if (reset_instr_event) begin
      rc_nxt[iwrc_pkg::RC_RI] = 1'b0;
    end
    if (bor_event || !vreg_enable) begin
      rc_nxt[iwrc_pkg::RC_BOR] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_r <= iwrc_pkg::RC_RESET;
      pc_r <= iwrc_pkg::PC_RESET;
      mode_r <= iwrc_pkg::M_RUN;
      src_r <= iwrc_pkg::SRC_MAIN;
      irq_wake_r <= 1'b0;
      gie_r <= 1'b0;
    end else begin
      rc_r <= rc_nxt;
      pc_r <= pc_nxt;
      mode_r <= mode_nxt;
      src_r <= src_nxt;
      irq_wake_r <= irq_wake_nxt;
      gie_r <= gie_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  wire wake_end = (mode_r == iwrc_pkg::M_WAKE) && dly_done && !rst_evt;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_r <= 1'b1;
      main_on_r <= 1'b1;
      sec_on_r <= 1'b0;
      int_on_r <= 1'b0;
      mflag_r <= 1'b1;
      sflag_r <= 1'b0;
      wclr_r <= 1'b0;
      wrst_r <= 1'b0;
      resume_r <= 1'b0;
      vec_r <= 1'b0;
    end else begin
      cpu_r <= (mode_nxt == iwrc_pkg::M_RUN);
      main_on_r <= (src_nxt == iwrc_pkg::SRC_MAIN);
      sec_on_r <= (src_nxt == iwrc_pkg::SRC_SEC) || t1en;
      int_on_r <= (src_nxt == iwrc_pkg::SRC_INT) || wdt_en ||
                  fscm_en;
      mflag_r <= (src_nxt == iwrc_pkg::SRC_MAIN);
      sflag_r <= (src_nxt == iwrc_pkg::SRC_SEC);
      wclr_r <= sleep_ok || watchdog_clear_instr ||
                (clock_lost && fscm_en);
      wrst_r <= wdt_rst;
      resume_r <= wake_end;
      vec_r <= wake_end && irq_wake_r && gie_r;
    end
  end

  assign cpu_clk_en = cpu_r;
  assign periph_src = src_r;
  assign main_osc_on = main_on_r;
  assign sec_osc_on = sec_on_r;
  assign int_osc_on = int_on_r;
  assign main_clock_active_flag = mflag_r;
  assign secondary_clock_active_flag = sflag_r;
  assign wdt_clear = wclr_r;
  assign wdt_reset_req = wrst_r;
  assign cpu_resume = resume_r;
  assign irq_vector_branch = vec_r;
  assign irq_level_enable = rc_r[iwrc_pkg::RC_IRQ_LEVEL_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_clean_idle_wake;
    (mode_r == iwrc_pkg::M_IDLE && wake_any && !rst_evt)
      ##1 (!rst_evt) [*8];
  endsequence

  sequence s_sec_entry;
    in_run && sleep_instr && idle_on_sleep_select && system_clock_select == iwrc_pkg::SCS_SEC && t1en;
  endsequence

  a_idle_cpu_off: assert property (
    (mode_r == iwrc_pkg::M_IDLE && src_r == iwrc_pkg::SRC_MAIN) |->
      (!cpu_clk_en && main_clock_active_flag && main_osc_on))
    else $error("main idle clocks wrong");

  a_wake_cpu_off: assert property (
    (mode_r == iwrc_pkg::M_WAKE) |-> !cpu_clk_en)
    else $error("cpu clocked during wake delay");

  a_wake_resume: assert property (
    s_clean_idle_wake |=> (cpu_clk_en && cpu_resume && $rose(cpu_clk_en)))
    else $error("idle wake delay not eight cycles");

  a_sec_entry: assert property (
    s_sec_entry |=> (!main_clock_active_flag &&
      secondary_clock_active_flag && !main_osc_on))
    else $error("secondary idle entry flags wrong");

  a_sec_ignore: assert property (
    (in_run && sleep_instr && sec_bad) |=> (mode_r == iwrc_pkg::M_RUN))
    else $error("sleep not ignored");

  a_irq_wake: assert property (
    (asleep && wake_irq && !rst_evt) |=> (mode_r == iwrc_pkg::M_WAKE))
    else $error("interrupt did not start wake");

  a_vector_branch: assert property (
    (wake_end && irq_wake_r) |=> (irq_vector_branch == $past(gie_r)))
    else $error("vector branch mismatch");

  a_wdt_run_reset: assert property (
    (in_run && wdt_timeout) |=> (wdt_reset_req && !rc_r[iwrc_pkg::RC_TO]))
    else $error("watchdog in run did not reset");

  a_wdt_clear: assert property (
    watchdog_clear_instr |=> wdt_clear)
    else $error("watchdog not cleared");

  a_reset_to_rc: assert property (
    (!in_run && rst_evt) |=> (periph_src == iwrc_pkg::SRC_INT && cpu_clk_en))
    else $error("reset exit not on internal rc");

  a_sleep_flags: assert property (
    (sleep_ok && !idle_on_sleep_select) |=> (!main_clock_active_flag &&
      !secondary_clock_active_flag && !main_osc_on))
    else $error("sleep left clock flags set");

  a_sleep_pd: assert property (
    (sleep_ok && !wdt_timeout && !watchdog_clear_instr) |=>
      (!rc_r[iwrc_pkg::RC_PD] && rc_r[iwrc_pkg::RC_TO]))
    else $error("sleep flags in cause register wrong");

  a_bor_vreg: assert property (
    !vreg_enable |=> !rc_r[iwrc_pkg::RC_BOR])
    else $error("brownout flag set with regulator off");
endmodule // iwrc_top

/* File: tb/iwrc_cpu_model.sv */
// Purpose: Processor core stand-in that issues sleep and watchdog clear
// Assumes: go bits are one-cycle requests from the bench
// Notes:   A stopped core executes nothing, so requests then are dropped
`timescale 1ns/100ps
module iwrc_cpu_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cpu_clk_en,
  input wire logic [1:0] go,
  output logic sleep_instr,
  output logic watchdog_clear_instr
);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_instr <= 1'h0;
      watchdog_clear_instr <= 1'h0;
    end else begin
      sleep_instr <= go[0] & cpu_clk_en;
      watchdog_clear_instr <= go[1] & cpu_clk_en;
    end
  end
endmodule // iwrc_cpu_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the idle, wake and reset-cause block
// Assumes: Ack and outputs are read at the edge, before that edge's updates
// Notes:   External clock mode is used so wakes skip the start-up wait
`timescale 1ns/100ps
module tb;
  logic core_clk, arst_n = 1'h0, wb_ack_o, slp, wclr;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic gie = 1'h0, vreg = 1'h1, cpu_clk_en, main_osc_on, sec_osc_on;
  logic int_osc_on, main_flag, sec_flag, wdt_clear, wdt_reset_req;
  logic cpu_resume, irq_vector_branch, irq_level_enable;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [7:0] irq_f = 8'h0, q;
  logic [4:0] ev = 5'h0;
  logic [1:0] go = 2'h0, periph_src;
  int errors = 0, checks = 0, cyc = 0;
  iwrc_top i_iwrc_top (.core_clk(core_clk), .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_instr(slp),
    .watchdog_clear_instr(wclr), .irq_flags(irq_f), .irq_enables(8'h01),
    .global_irq_enable(gie), .wdt_timeout(ev[3]), .clock_lost(ev[4]),
    .bor_event(ev[0]), .cm_event(ev[1]), .reset_instr_event(ev[2]),
    .vreg_enable(vreg), .main_osc_config(iwrc_pkg::MAIN_OSC_CONFIG_EC),
    .cpu_clk_en(cpu_clk_en), .periph_src(periph_src),
    .main_osc_on(main_osc_on), .sec_osc_on(sec_osc_on),
    .int_osc_on(int_osc_on), .main_clock_active_flag(main_flag),
    .secondary_clock_active_flag(sec_flag), .wdt_clear(wdt_clear),
    .wdt_reset_req(wdt_reset_req), .cpu_resume(cpu_resume),
    .irq_vector_branch(irq_vector_branch),
    .irq_level_enable(irq_level_enable));
  iwrc_cpu_model i_iwrc_cpu_model (.core_clk(core_clk), .arst_n(arst_n),
    .cpu_clk_en(cpu_clk_en), .go(go), .sleep_instr(slp),
    .watchdog_clear_instr(wclr));
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done, errors %0d", s, errors);
  endtask
  // Request held until ack is sampled; the wait is bounded
  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n == 20) errors++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input string s,
                    input logic [7:0] e);
    bus(1'h0, a, 8'h0);
    chk(s, e, q);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'h1;
    @(posedge core_clk);
    ev <= 5'h0;
    @(posedge core_clk);
  endtask
  // Core model adds one cycle before the instruction reaches the block
  task automatic cpu(input int k);
    go[k] <= 1'h1;
    @(posedge core_clk);
    go <= 2'h0;
    repeat (2) @(posedge core_clk);
  endtask
  // Caller raises the wake cause at the current edge
  task automatic wake(input logic br);
    @(posedge core_clk);
    ev <= 5'h0;
    irq_f <= 8'h0;
    @(posedge core_clk);
    chk("wdt_reset_req", 8'h0, wdt_reset_req);
    repeat (7) @(posedge core_clk);
    chk("clk_en early", 8'h0, cpu_clk_en);
    @(posedge core_clk);
    chk("clk_en", 8'h1, cpu_clk_en);
    chk("resume", 8'h1, cpu_resume);
    chk("branch", {7'h0, br}, irq_vector_branch);
    @(posedge core_clk);
    chk("resume end", 8'h0, cpu_resume);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'h1;
    @(posedge core_clk);
    rd(iwrc_pkg::ADR_RCAUSE, "rcause", 8'h3C);
    rd(iwrc_pkg::ADR_PCTRL, "pctrl", 8'h04);
    rd(iwrc_pkg::ADR_PSTAT, "pstat", 8'h38);
    rd(4'hC, "unmapped", 8'h00);
    chk("irq_level_enable", 8'h0, irq_level_enable);
    endt("reset");
    wr(iwrc_pkg::ADR_RCAUSE, 8'hFF);
    rd(iwrc_pkg::ADR_RCAUSE, "rcause rw", 8'hBF);
    chk("irq_level_enable set", 8'h1, irq_level_enable);
    vreg <= 1'h0;
    @(posedge core_clk);
    rd(iwrc_pkg::ADR_RCAUSE, "bor off", 8'hBE);
    vreg <= 1'h1;
    wr(iwrc_pkg::ADR_RCAUSE, 8'hFF);
    pulse(0);
    rd(iwrc_pkg::ADR_RCAUSE, "bor", 8'hBE);
    pulse(1);
    rd(iwrc_pkg::ADR_RCAUSE, "cm", 8'h9E);
    pulse(2);
    rd(iwrc_pkg::ADR_RCAUSE, "ri", 8'h8E);
    pulse(3);
    chk("wdt reset", 8'h1, wdt_reset_req);
    rd(iwrc_pkg::ADR_RCAUSE, "to", 8'h86);
    cpu(1);
    chk("watchdog_clear_instr", 8'h1, wdt_clear);
    rd(iwrc_pkg::ADR_RCAUSE, "clr", 8'h8E);
    for (int i = 0; i < 2; i++) begin
      wr(iwrc_pkg::ADR_PCTRL, i ? 8'h24 : 8'h04);
      pulse(4);
      chk("clk lost", i[7:0], wdt_clear);
    end
    wr(iwrc_pkg::ADR_PCTRL, 8'h04);
    endt("rcause");
    cpu(0);
    chk("sleep clr", 8'h1, wdt_clear);
    chk("sleep flags", 8'h0, {main_flag, sec_flag});
    rd(iwrc_pkg::ADR_RCAUSE, "sleep", 8'h8A);
    gie <= 1'h1;
    irq_f <= 8'h01;
    wake(1'h1);
    chk("main back", 8'h1, main_flag);
    endt("sleep");
    wr(iwrc_pkg::ADR_PCTRL, 8'h01);
    wr(iwrc_pkg::ADR_PCTRL, 8'h05);
    cpu(0);
    chk("midle", 8'h0E, {cpu_clk_en, main_osc_on, main_flag, periph_src});
    rd(iwrc_pkg::ADR_PSTAT, "midle st", 8'h29);
    gie <= 1'h0;
    irq_f <= 8'h02;
    repeat (12) @(posedge core_clk);
    chk("masked irq", 8'h0, cpu_clk_en);
    irq_f <= 8'h01;
    wake(1'h0);
    chk("midle wake", 8'h6, {main_flag, periph_src});
    endt("main idle");
    wr(iwrc_pkg::ADR_PCTRL, 8'h03);
    cpu(0);
    chk("refused", 8'h3, {cpu_clk_en, main_flag});
    wr(iwrc_pkg::ADR_PCTRL, 8'h0B);
    cpu(0);
    chk("sidle", 8'h5, {main_osc_on, main_flag, sec_flag, periph_src});
    ev[3] <= 1'h1;
    wake(1'h0);
    chk("sidle wake", 8'hD, {sec_osc_on, sec_flag, periph_src});
    rd(iwrc_pkg::ADR_RCAUSE, "wdt wake", 8'h82);
    endt("secondary idle");
    wr(iwrc_pkg::ADR_PCTRL, 8'h19);
    cpu(0);
    chk("ridle", 8'h0, {main_flag, periph_src});
    irq_f <= 8'h01;
    wake(1'h0);
    chk("ridle wake", 8'h4, {int_osc_on, periph_src});
    endt("internal idle");
    wr(iwrc_pkg::ADR_RCAUSE, 8'hB3);
    wr(iwrc_pkg::ADR_PCTRL, 8'h05);
    cpu(0);
    pulse(1);
    chk("rst exit", 8'hC, {cpu_clk_en, int_osc_on, periph_src});
    rd(iwrc_pkg::ADR_RCAUSE, "rst cm", 8'h9B);
    endt("reset exit");
    finish_test;
  end
endmodule // tb
